//--- verilog/dbs_pkg.sv
package dbs_pkg;
  // Bus geometry
  localparam int ADDR_W    = 20;
  localparam int DATA_W    = 18;
  localparam int BURST_LEN = 4;
  localparam int BEAT_W    = 2;
  localparam int HALF_W    = 5;
  localparam int LOCK_W    = 12;
  localparam int CNT_W     = 13;
  localparam int MEM_DEPTH = 1 << ADDR_W;

  // Clock and link timing
  localparam int CLK_PERIOD_NS    = 25;
  localparam int KSTOP_MIN_NS     = 30;
  localparam int KSTOP_CYC        = (KSTOP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLL_LOCK_PERIOD  = 2048;
  localparam int DLL_DISABLE_LOW_MIN_TIME_NS = 100;
  localparam int DLL_DISABLE_LOW_MIN_CYC =
    (DLL_DISABLE_LOW_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Half-cycle positions counted from the command edge
  localparam logic [HALF_W-1:0] HALF_FIRST = 5'h01;
  localparam logic [HALF_W-1:0] RD_LAT_DLL = 5'h05;
  localparam logic [HALF_W-1:0] RD_LAT_BYP = 5'h02;
  localparam logic [HALF_W-1:0] WR_LAT     = 5'h0c;
  localparam logic [HALF_W-1:0] BURST_SPAN = 5'h04;
  localparam logic [BEAT_W-1:0] LAST_BEAT  = 2'h3;

  typedef enum logic [2:0] {
    DS_IDLE  = 3'b001,
    DS_READ  = 3'b010,
    DS_WRITE = 3'b100
  } dbs_dev_st_t;

  typedef enum logic [4:0] {
    CS_INIT  = 5'b00001,
    CS_LOCK  = 5'b00010,
    CS_IDLE  = 5'b00100,
    CS_READ  = 5'b01000,
    CS_WRITE = 5'b10000
  } dbs_ctl_st_t;

  // Linear burst address, wraps at the top of the array
  function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base,
                                                   input logic [BEAT_W-1:0] beat);
    return base + ADDR_W'(beat);
  endfunction
endpackage

//--- verilog/dbs_link_if.sv
interface dbs_link_if;
  import dbs_pkg::*;
  logic              k;
  logic              k_n;
  logic              load_strobe_n;
  logic              rw;
  logic              dll_bypass_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dev_dq_o;
  logic              dev_dq_oe;
  logic [DATA_W-1:0] ctl_dq_o;
  logic              ctl_dq_oe;
  logic [DATA_W-1:0] dq;

  // Resolved common data bus; the device enable says who drives, idle shows controller data
  assign dq = dev_dq_oe ? dev_dq_o : ctl_dq_o;

  modport dev (input k, k_n, load_strobe_n, rw, dll_bypass_n, addr, dq,
               output dev_dq_o, dev_dq_oe);
  modport ctl (output k, k_n, load_strobe_n, rw, dll_bypass_n, addr, ctl_dq_o, ctl_dq_oe,
               input dq);
endinterface

//--- verilog/dbs_dll_track.sv
module dbs_dll_track
  import dbs_pkg::*;
#(
  parameter int LOCK_CYCLES = DLL_LOCK_PERIOD
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic k,
  input  wire logic k_n,
  input  wire logic bypass_n,
  output logic      k_rise,
  output logic      kn_rise,
  output logic      locked
);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES);
  localparam logic [1:0]        STOP_LAST = 2'(KSTOP_CYC);

  logic              k_q;
  logic              kn_q;
  logic              byp_q;
  logic              locked_q;
  logic              locked_d;
  logic              dll_rst;
  logic [1:0]        stop_q;
  logic [1:0]        stop_d;
  logic [LOCK_W-1:0] lock_q;
  logic [LOCK_W-1:0] lock_d;

  // Rising edges of both input clocks
  assign k_rise  = k & ~k_q;
  assign kn_rise = k_n & ~kn_q;
  assign locked  = locked_q;

  // Stop detection and lock counting
  always_comb begin
    stop_d = stop_q;
    if (k != k_q || k_n != kn_q) begin
      stop_d = '0;
    end else if (stop_q < STOP_LAST) begin
      stop_d = stop_q + 1'b1;
    end
    dll_rst  = (stop_q >= STOP_LAST) | (bypass_n & ~byp_q);
    lock_d   = lock_q;
    locked_d = locked_q;
    if (dll_rst) begin
      lock_d   = '0;
      locked_d = 1'b0;
    end else if (k_rise && !locked_q) begin
      lock_d   = lock_q + 1'b1;
      locked_d = (lock_d == LOCK_LAST);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      k_q      <= 1'b0;
      kn_q     <= 1'b0;
      byp_q    <= 1'b0;
      stop_q   <= '0;
      lock_q   <= '0;
      locked_q <= 1'b0;
    end else begin
      k_q      <= k;
      kn_q     <= k_n;
      byp_q    <= bypass_n;
      stop_q   <= stop_d;
      lock_q   <= lock_d;
      locked_q <= locked_d;
    end
  end
endmodule

//--- verilog/dbs_sram_dev.sv
module dbs_sram_dev
  import dbs_pkg::*;
#(
  parameter int LOCK_CYCLES = DLL_LOCK_PERIOD
) (
  input  wire logic clk,
  input  wire logic rst_n,
  dbs_link_if.dev   link,
  output logic      ready,
  output logic      dll_locked
);
  logic              k_rise;
  logic              kn_rise;
  logic              half_ev;
  dbs_dev_st_t       st_q;
  dbs_dev_st_t       st_d;
  logic [HALF_W-1:0] h_q;
  logic [HALF_W-1:0] h_d;
  logic [HALF_W-1:0] lat_q;
  logic [HALF_W-1:0] lat_d;
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] base_d;
  logic [DATA_W-1:0] dq_q;
  logic [DATA_W-1:0] dq_d;
  logic              oe_q;
  logic              oe_d;
  logic              ready_q;
  logic              ready_d;
  logic [ADDR_W-1:0] wb_addr_q [2];
  logic [ADDR_W-1:0] wb_addr_d [2];
  logic [DATA_W-1:0] wb_data_q [2][BURST_LEN];
  logic [DATA_W-1:0] wb_data_d [2][BURST_LEN];
  logic [1:0]        wb_vld_q;
  logic [1:0]        wb_vld_d;
  logic              commit;
  logic [BEAT_W-1:0] rd_beat;
  logic [BEAT_W-1:0] wr_beat;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] mem_q [0:MEM_DEPTH-1];

  // DLL tracking from the input clock pair
  dbs_dll_track #(
    .LOCK_CYCLES (LOCK_CYCLES)
  ) u_dll (
    .clk      (clk),
    .rst_n    (rst_n),
    .k        (link.k),
    .k_n      (link.k_n),
    .bypass_n (link.dll_bypass_n),
    .k_rise   (k_rise),
    .kn_rise  (kn_rise),
    .locked   (dll_locked)
  );

  // Every input clock rising edge is one half cycle
  assign half_ev = k_rise | kn_rise;
  assign rd_beat = BEAT_W'(h_q - lat_q);
  assign wr_beat = BEAT_W'(h_q - WR_LAT);

  // Read word: newer write buffer wins over older, then array
  always_comb begin
    rd_addr = burst_addr(base_q, rd_beat);
    rd_word = mem_q[rd_addr];
    for (int s = 1; s >= 0; s--) begin
      for (int i = 0; i < BURST_LEN; i++) begin
        if (wb_vld_q[s] && burst_addr(wb_addr_q[s], BEAT_W'(i)) == rd_addr) begin
          rd_word = wb_data_q[s][i];
        end
      end
    end
  end

  // Command decode and burst sequencing
  always_comb begin
    st_d      = st_q;
    h_d       = h_q;
    lat_d     = lat_q;
    base_d    = base_q;
    dq_d      = dq_q;
    oe_d      = oe_q;
    wb_addr_d = wb_addr_q;
    wb_data_d = wb_data_q;
    wb_vld_d  = wb_vld_q;
    commit    = 1'b0;
    ready_d   = !link.dll_bypass_n || dll_locked;
    if (half_ev) begin
      h_d = h_q + 1'b1;
    end
    case (st_q)
      DS_IDLE: begin
        // Strobe high is a no-op and the bus stays released
        if (k_rise && !link.load_strobe_n && ready_q) begin
          base_d = link.addr;
          h_d    = HALF_FIRST;
          if (link.rw) begin
            st_d  = DS_READ;
            lat_d = link.dll_bypass_n ? RD_LAT_DLL : RD_LAT_BYP;
          end else begin
            st_d         = DS_WRITE;
            commit       = wb_vld_q[1];
            wb_addr_d[1] = wb_addr_q[0];
            wb_data_d[1] = wb_data_q[0];
            wb_vld_d[1]  = wb_vld_q[0];
            wb_addr_d[0] = link.addr;
            wb_vld_d[0]  = 1'b0;
          end
        end
      end
      DS_READ: begin
        if (half_ev) begin
          if (h_q >= lat_q && h_q < lat_q + BURST_SPAN) begin
            dq_d = rd_word;
            oe_d = 1'b1;
          end else if (h_q == lat_q + BURST_SPAN) begin
            oe_d = 1'b0;
            st_d = DS_IDLE;
          end
        end
      end
      DS_WRITE: begin
        // Capture one beat per half cycle into the newest buffer
        if (half_ev && h_q >= WR_LAT) begin
          wb_data_d[0][wr_beat] = link.dq;
          if (wr_beat == LAST_BEAT) begin
            wb_vld_d[0] = 1'b1;
            st_d        = DS_IDLE;
          end
        end
      end
      default: begin
        st_d = DS_IDLE;
        oe_d = 1'b0;
      end
    endcase
  end

  // Control and buffer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= DS_IDLE;
      h_q       <= '0;
      lat_q     <= RD_LAT_DLL;
      base_q    <= '0;
      dq_q      <= '0;
      oe_q      <= 1'b0;
      ready_q   <= 1'b0;
      wb_addr_q <= '{default: '0};
      wb_data_q <= '{default: '0};
      wb_vld_q  <= '0;
    end else begin
      st_q      <= st_d;
      h_q       <= h_d;
      lat_q     <= lat_d;
      base_q    <= base_d;
      dq_q      <= dq_d;
      oe_q      <= oe_d;
      ready_q   <= ready_d;
      wb_addr_q <= wb_addr_d;
      wb_data_q <= wb_data_d;
      wb_vld_q  <= wb_vld_d;
    end
  end

  // Oldest buffer retires to the array when a third write starts
  always_ff @(posedge clk) begin
    if (commit) begin
      for (int i = 0; i < BURST_LEN; i++) begin
        mem_q[burst_addr(wb_addr_q[1], BEAT_W'(i))] <= wb_data_q[1][i];
      end
    end
  end

  // Data pins driven from registers
  assign link.dev_dq_o  = dq_q;
  assign link.dev_dq_oe = oe_q;
  assign ready          = ready_q;
endmodule

//--- verilog/dbs_sram_ctl.sv
module dbs_sram_ctl
  import dbs_pkg::*;
#(
  parameter int LOCK_CYCLES = DLL_LOCK_PERIOD
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  dbs_link_if.ctl                            link,
  input  wire logic                          use_dll,
  input  wire logic                          dll_reset_req,
  input  wire logic                          req_valid,
  input  wire logic                          req_write,
  input  wire logic [ADDR_W-1:0]             req_addr,
  input  wire logic [BURST_LEN*DATA_W-1:0]   req_wdata,
  output logic                               req_ready,
  output logic                               rd_valid,
  output logic      [BURST_LEN*DATA_W-1:0]   rd_data,
  output logic                               mem_ready
);
  localparam int BW = BURST_LEN * DATA_W;
  localparam logic [CNT_W-1:0] LOW_WAIT  = CNT_W'(DLL_DISABLE_LOW_MIN_CYC + 1);
  localparam logic [CNT_W-1:0] LOCK_WAIT = CNT_W'(2 * LOCK_CYCLES + 2);
  localparam logic [CNT_W-1:0] WR_FIRST  = CNT_W'(WR_LAT) - 1'b1;
  localparam logic [CNT_W-1:0] WR_END    = CNT_W'(WR_LAT + BURST_SPAN) - 1'b1;

  dbs_ctl_st_t       st_q, st_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [HALF_W-1:0] lat_q, lat_d;
  logic              k_q, kn_q, ld_n_q, ld_n_d, rw_q, rw_d, byp_n_q, byp_n_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] dq_q, dq_d;
  logic              oe_q, oe_d, pend_q, pend_d;
  logic [BW-1:0]     wdata_q, wdata_d, rdata_q, rdata_d;
  logic              rd_valid_q, rd_valid_d, req_ready_q, req_ready_d;
  logic              mem_ready_q, mem_ready_d;

  // Initialisation, command issue and beat timing
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q + 1'b1;
    lat_d   = lat_q;
    ld_n_d  = 1'b1;
    rw_d    = rw_q;
    byp_n_d = byp_n_q;
    addr_d  = addr_q;
    dq_d    = dq_q;
    oe_d    = oe_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    rd_valid_d = 1'b0;
    pend_d  = pend_q | dll_reset_req;
    case (st_q)
      CS_INIT: begin
        byp_n_d = 1'b0;
        if (cnt_q >= LOW_WAIT) begin
          st_d    = CS_LOCK;
          cnt_d   = '0;
          byp_n_d = use_dll;
        end
      end
      CS_LOCK: begin
        if (cnt_q >= LOCK_WAIT) begin
          st_d = CS_IDLE;
        end
      end
      CS_IDLE: begin
        if (pend_q) begin
          st_d    = CS_INIT;
          cnt_d   = '0;
          byp_n_d = 1'b0;
          pend_d  = dll_reset_req;
        end else if (req_valid && req_ready_q) begin
          ld_n_d  = 1'b0;
          rw_d    = !req_write;
          addr_d  = req_addr;
          wdata_d = req_wdata;
          cnt_d   = '0;
          lat_d   = byp_n_q ? RD_LAT_DLL : RD_LAT_BYP;
          st_d    = req_write ? CS_WRITE : CS_READ;
        end
      end
      CS_READ: begin
        if (cnt_q > CNT_W'(lat_q) && cnt_q <= CNT_W'(lat_q + BURST_SPAN)) begin
          rdata_d = {link.dq, rdata_q[BW-1:DATA_W]};
        end
        if (cnt_q == CNT_W'(lat_q + BURST_SPAN)) begin
          rd_valid_d = 1'b1;
          st_d       = CS_IDLE;
        end
      end
      CS_WRITE: begin
        // Drive only in the beat window, released otherwise
        if (cnt_q >= WR_FIRST && cnt_q < WR_END) begin
          dq_d    = wdata_q[DATA_W-1:0];
          wdata_d = wdata_q >> DATA_W;
          oe_d    = 1'b1;
        end else if (cnt_q == WR_END) begin
          oe_d = 1'b0;
          st_d = CS_IDLE;
        end
      end
      default: begin
        st_d = CS_INIT;
        oe_d = 1'b0;
      end
    endcase
    // Ready only in the half cycle before a K rise
    req_ready_d = (st_d == CS_IDLE) && k_q && !pend_d;
    mem_ready_d = (st_d != CS_INIT) && (st_d != CS_LOCK);
  end

  // All link pins held at defined levels from reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= CS_INIT;
      cnt_q <= '0;
      lat_q <= RD_LAT_DLL;
      k_q <= 1'b0;
      kn_q <= 1'b1;
      ld_n_q <= 1'b1;
      rw_q <= 1'b1;
      byp_n_q <= 1'b0;
      addr_q <= '0;
      dq_q <= '0;
      oe_q <= 1'b0;
      pend_q <= 1'b0;
      wdata_q <= '0;
      rdata_q <= '0;
      rd_valid_q <= 1'b0;
      req_ready_q <= 1'b0;
      mem_ready_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      lat_q <= lat_d;
      k_q <= ~k_q;
      kn_q <= k_q;
      ld_n_q <= ld_n_d;
      rw_q <= rw_d;
      byp_n_q <= byp_n_d;
      addr_q <= addr_d;
      dq_q <= dq_d;
      oe_q <= oe_d;
      pend_q <= pend_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rd_valid_q <= rd_valid_d;
      req_ready_q <= req_ready_d;
      mem_ready_q <= mem_ready_d;
    end
  end

  assign link.k             = k_q;
  assign link.k_n           = kn_q;
  assign link.load_strobe_n = ld_n_q;
  assign link.rw            = rw_q;
  assign link.dll_bypass_n  = byp_n_q;
  assign link.addr          = addr_q;
  assign link.ctl_dq_o      = dq_q;
  assign link.ctl_dq_oe     = oe_q;
  assign req_ready          = req_ready_q;
  assign rd_valid           = rd_valid_q;
  assign rd_data            = rdata_q;
  assign mem_ready          = mem_ready_q;
endmodule

//--- tb/dbs_link_checker.sv
// Protocol watcher on the link between controller and device
module dbs_link_checker
  import dbs_pkg::*;
#(
  parameter int LOCK_CYCLES = DLL_LOCK_PERIOD
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic k,
  input wire logic k_n,
  input wire logic load_strobe_n,
  input wire logic rw,
  input wire logic dll_bypass_n,
  input wire logic dev_dq_oe,
  input wire logic ctl_dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        k_q;
  logic        bp_q;
  logic [15:0] lock_q;
  logic [15:0] lock_d;
  logic        rd_ld;
  logic        wr_ld;

  // Command loads on a true-clock rise
  assign rd_ld = k && !k_q && !load_strobe_n && rw;
  assign wr_ld = k && !k_q && !load_strobe_n && !rw;

  // Cycles since the last rise of the bypass pin
  always_comb begin
    lock_d = lock_q;
    if (dll_bypass_n && !bp_q) begin
      lock_d = 16'h0000;
    end else if (lock_q != 16'hffff) begin
      lock_d = lock_q + 16'h0001;
    end
  end

  // Helper registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      k_q    <= 1'b0;
      bp_q   <= 1'b0;
      lock_q <= 16'h0000;
    end else begin
      k_q    <= k;
      bp_q   <= dll_bypass_n;
      lock_q <= lock_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_rd_dll;
    rd_ld && dll_bypass_n |-> ##6 dev_dq_oe [*4] ##1 !dev_dq_oe;
  endproperty
  property p_rd_byp;
    rd_ld && !dll_bypass_n |-> ##3 dev_dq_oe [*4] ##1 !dev_dq_oe;
  endproperty
  property p_wr;
    wr_ld |-> ##12 ctl_dq_oe [*4] ##1 !ctl_dq_oe;
  endproperty
  property p_k_pair;
    $past(rst_n) |-> k_n == !k && k != $past(k);
  endproperty
  property p_release;
    $rose(ctl_dq_oe) |-> !$past(dev_dq_oe) && !dev_dq_oe;
  endproperty
  property p_nop_quiet;
    $rose(dev_dq_oe) |-> $past(rd_ld, 6) || $past(rd_ld, 3);
  endproperty
  property p_ld_pulse;
    !load_strobe_n |-> k && !k_q ##1 load_strobe_n;
  endproperty
  property p_lock_wait;
    !load_strobe_n && dll_bypass_n |-> lock_q >= 16'(2 * LOCK_CYCLES);
  endproperty

  a_rd_dll: assert property (p_rd_dll) else $error("read burst timing wrong");
  a_rd_byp: assert property (p_rd_byp) else $error("bypass read timing wrong");
  a_wr: assert property (p_wr) else $error("write data window wrong");
  a_k_pair: assert property (p_k_pair) else $error("clock pair not running");
  a_release: assert property (p_release) else $error("bus not released first");
  a_nop_quiet: assert property (p_nop_quiet) else $error("device drove without read");
  a_ld_pulse: assert property (p_ld_pulse) else $error("load strobe misplaced");
  a_lock_wait: assert property (p_lock_wait) else $error("command before lock");

  c_rd_dll: cover property (rd_ld && dll_bypass_n);
  c_rd_byp: cover property (rd_ld && !dll_bypass_n);
  c_wr: cover property (wr_ld);
  c_relock: cover property ($rose(dll_bypass_n));
endmodule

//--- tb/ddr_burst4_sram_init_and_cmd_tb.sv
module ddr_burst4_sram_init_and_cmd_tb;
  import dbs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int LC = 16;

  logic                        clk;
  logic                        rst_n;
  logic                        use_dll;
  logic                        dll_reset_req;
  logic                        req_valid;
  logic                        req_write;
  logic [ADDR_W-1:0]           req_addr;
  logic [BURST_LEN*DATA_W-1:0] req_wdata;
  logic                        req_ready;
  logic                        rd_valid;
  logic [BURST_LEN*DATA_W-1:0] rd_data;
  logic                        mem_ready;
  logic                        dev_ready;
  logic                        dll_locked;
  int                          bad_count;
  int                          n_tests;

  dbs_link_if link();

  dbs_sram_dev #(.LOCK_CYCLES(LC)) u_dbs_sram_dev (
    .clk(clk), .rst_n(rst_n), .link(link), .ready(dev_ready), .dll_locked(dll_locked));

  dbs_sram_ctl #(.LOCK_CYCLES(LC)) u_dbs_sram_ctl (
    .clk(clk), .rst_n(rst_n), .link(link), .use_dll(use_dll),
    .dll_reset_req(dll_reset_req), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .mem_ready(mem_ready));

  dbs_link_checker #(.LOCK_CYCLES(LC)) u_dbs_link_checker (
    .clk(clk), .rst_n(rst_n), .k(link.k), .k_n(link.k_n),
    .load_strobe_n(link.load_strobe_n), .rw(link.rw), .dll_bypass_n(link.dll_bypass_n),
    .dev_dq_oe(link.dev_dq_oe), .ctl_dq_oe(link.ctl_dq_oe));

  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [BURST_LEN*DATA_W-1:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Four beats counting up from a seed
  function automatic logic [BURST_LEN*DATA_W-1:0] pat(input logic [DATA_W-1:0] s);
    return {s + 18'h00003, s + 18'h00002, s + 18'h00001, s};
  endfunction

  // One user request, held until taken
  task automatic issue(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [BURST_LEN*DATA_W-1:0] d);
    int i;
    req_valid = 1'b1;
    req_write = w;
    req_addr  = a;
    req_wdata = d;
    i = 0;
    while (req_ready !== 1'b1 && i < 300) begin
      tick(1);
      i++;
    end
    tick(1);
    req_valid = 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [BURST_LEN*DATA_W-1:0] exp);
    int i;
    issue(1'b0, a, '0);
    i = 0;
    while (rd_valid !== 1'b1 && i < 40) begin
      tick(1);
      i++;
    end
    check(rd_data, exp);
  endtask

  // Span from bypass pin rise to DLL lock, then readiness
  task automatic lock_span();
    int i;
    int n;
    i = 0;
    while (link.dll_bypass_n !== 1'b1 && i < 100) begin
      tick(1);
      i++;
    end
    // Let the reset from the pin edge clear a lock left from before
    tick(1);
    n = 1;
    while (dll_locked !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    check(n >= 2 * LC - 4 && n <= 2 * LC + 4, 1'b1);
    i = 0;
    while (mem_ready !== 1'b1 && i < 200) begin
      tick(1);
      i++;
    end
    check({mem_ready, dev_ready}, 2'h3);
  endtask

  task automatic t_power_up();
    lock_span();
    $display("test power_up done");
  endtask

  task automatic t_linear();
    issue(1'b1, 20'h00100, pat(18'h00010));
    issue(1'b1, 20'h00102, pat(18'h00020));
    rd_chk(20'h00100, {18'h00021, 18'h00020, 18'h00011, 18'h00010});
    rd_chk(20'h00101, {18'h00022, 18'h00021, 18'h00020, 18'h00011});
    issue(1'b1, 20'h00104, pat(18'h00030));
    rd_chk(20'h00100, {18'h00021, 18'h00020, 18'h00011, 18'h00010});
    rd_chk(20'h00103, {18'h00032, 18'h00031, 18'h00030, 18'h00021});
    $display("test linear done");
  endtask

  task automatic t_wrap();
    issue(1'b1, 20'h00000, pat(18'h00040));
    issue(1'b1, 20'hffffe, pat(18'h00050));
    rd_chk(20'h00000, {18'h00043, 18'h00042, 18'h00053, 18'h00052});
    rd_chk(20'hffffe, pat(18'h00050));
    $display("test wrap done");
  endtask

  task automatic t_nop();
    int hits;
    hits = 0;
    repeat (20) begin
      tick(1);
      if (link.dev_dq_oe !== 1'b0 || link.load_strobe_n !== 1'b1) hits++;
    end
    check(hits, 0);
    $display("test nop done");
  endtask

  task automatic t_relock(input logic dll_on);
    use_dll = dll_on;
    dll_reset_req = 1'b1;
    tick(1);
    dll_reset_req = 1'b0;
    tick(2);
    check(mem_ready, 1'b0);
    if (dll_on) begin
      lock_span();
    end else begin
      while (mem_ready !== 1'b1 && n_tests < 100000) tick(1);
      check({link.dll_bypass_n, dev_ready}, 2'h1);
    end
    rd_chk(20'h00101, {18'h00030, 18'h00021, 18'h00020, 18'h00011});
    issue(1'b1, 20'h00200, pat(18'h00060));
    rd_chk(20'h00200, pat(18'h00060));
    $display("test relock done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end

  // Main sequence
  initial begin
    bad_count     = 0;
    n_tests       = 0;
    rst_n         = 1'b0;
    use_dll       = 1'b1;
    dll_reset_req = 1'b0;
    req_valid     = 1'b0;
    req_write     = 1'b0;
    req_addr      = '0;
    req_wdata     = '0;
    tick(4);
    rst_n = 1'b1;
    t_power_up();
    t_linear();
    t_wrap();
    t_nop();
    t_relock(1'b1);
    t_relock(1'b0);
    complete_run();
  end
endmodule
